/* File: design/rtc_alarm_consts.vh */
`ifndef RTC_ALARM_CONSTS_VH
`define RTC_ALARM_CONSTS_VH
// register addresses
`define ADDR_FLAG_CONTROL   8'h01
`define ADDR_CLOCK_CONTROL  8'h00
`define ADDR_YEAR_COUNT     8'h08
`define ADDR_MINUTE_ALARM   8'h09
`define ADDR_HOUR_ALARM     8'h0A
`define ADDR_DAY_ALARM      8'h0B
`define ADDR_WEEKDAY_ALARM  8'h0C
`define ADDR_CD_CONTROL     8'h0E
`define ADDR_CD_VALUE       8'h0F
// flag_control field positions
`define BIT_TICK_FLAG       5
`define BIT_ALARM_FLAG      3
`define BIT_CD_FLAG         2
`define BIT_PERIODIC_60S    1
`define BIT_PERIODIC_1S     0
// alarm and control fields
`define BIT_MATCH_OFF       7
`define BIT_HOUR_12         2
`define BIT_CD_RUN          7
// source select codes
`define SRC_4096HZ          2'h0
`define SRC_64HZ            2'h1
`define SRC_1HZ             2'h2
`define SRC_60S             2'h3
// read masks per register
`define MASK_FLAG_CONTROL   8'h3F
`define MASK_HOUR_ALARM     8'hBF
`define MASK_DAY_ALARM      8'hBF
`define MASK_WEEKDAY_ALARM  8'h87
`define MASK_CD_CONTROL     8'h83
// timing: source tick periods in ns, system clock period in ns
`define CLK_PERIOD_NS       8
`define T4096_NS            244140
`define T64_NS              15625000
`define T1_NS               1000000000
`define T4096_CYC           (`T4096_NS / `CLK_PERIOD_NS)
`define T64_CYC             (`T64_NS / `CLK_PERIOD_NS)
`define T1_CYC              (`T1_NS / `CLK_PERIOD_NS)
`define MIN_SECONDS         6'h3B
// reset values
`define RST_BYTE            8'h00
`define RST_ALARM           8'h80
`define RST_CD_CONTROL      8'h03
`endif

/* File: design/rtc_alarm_timer.v */
`include "rtc_alarm_consts.vh"
`default_nettype none
module rtc_alarm_timer (
    // clock and reset
    input  wire       clk_sys,
    input  wire       rst,
    // register port from the serial interface layer
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_q,
    // current time from the calendar counters
    input  wire       minute_tick,
    input  wire       second_tick,
    input  wire [6:0] cur_minute,
    input  wire [5:0] cur_hour,
    input  wire [5:0] cur_day,
    input  wire [2:0] cur_weekday,
    // year carry from the month counter
    input  wire       year_tick,
    // flag levels for the interrupt logic, and the hour format bit
    output reg        alarm_flag_q,
    output reg        tick_flag_q,
    output reg        countdown_flag_q,
    output reg        hour_12_q
);
    reg  [7:0]  year_q;
    reg  [7:0]  minute_alarm_q;
    reg  [7:0]  hour_alarm_q;
    reg  [7:0]  day_alarm_q;
    reg  [7:0]  weekday_alarm_q;
    reg  [7:0]  cd_ctrl_q;
    reg  [7:0]  cd_n_q;
    reg  [7:0]  cd_count_q;
    reg         periodic_60s_en_q;
    reg         periodic_1s_en_q;
    reg  [31:0] pre_q;
    reg  [5:0]  sec_cnt_q;
    reg         min_q1;
    reg         min_q2;
    reg         sec_q1;
    reg         sec_q2;
    reg         yr_q1;
    reg         yr_q2;
    reg         min_d1;
    reg         sec_d1;
    reg         yr_d1;
    reg         src_tick;
    reg  [31:0] pre_max;
    reg  [7:0]  year_d;
    wire        min_event;
    wire        sec_event;
    wire        yr_event;
    wire        minute_match_off;
    wire        hour_match_off;
    wire        day_match_off;
    wire        weekday_match_off;
    wire        any_enabled;
    wire        all_match;
    wire        alarm_set;
    wire        tick_set;
    wire        cd_set;
    wire        countdown_run;
    wire [1:0]  countdown_src_sel;
    wire [5:0]  hour_mask;

    // calendar strobes come from the slow domain, so two flops before use
    always @(posedge clk_sys) begin
        if (rst) begin
            min_q1 <= 1'b0;
            min_q2 <= 1'b0;
            sec_q1 <= 1'b0;
            sec_q2 <= 1'b0;
            yr_q1  <= 1'b0;
            yr_q2  <= 1'b0;
            min_d1 <= 1'b0;
            sec_d1 <= 1'b0;
            yr_d1  <= 1'b0;
        end else begin
            min_q1 <= minute_tick;
            min_q2 <= min_q1;
            sec_q1 <= second_tick;
            sec_q2 <= sec_q1;
            yr_q1  <= year_tick;
            yr_q2  <= yr_q1;
            min_d1 <= min_q2;
            sec_d1 <= sec_q2;
            yr_d1  <= yr_q2;
        end
    end
    assign min_event = min_q2 & ~min_d1;
    assign sec_event = sec_q2 & ~sec_d1;
    assign yr_event  = yr_q2 & ~yr_d1;

    // field decode of the alarm registers
    assign minute_match_off  = minute_alarm_q[`BIT_MATCH_OFF];
    assign hour_match_off    = hour_alarm_q[`BIT_MATCH_OFF];
    assign day_match_off     = day_alarm_q[`BIT_MATCH_OFF];
    assign weekday_match_off = weekday_alarm_q[`BIT_MATCH_OFF];
    // in 12h mode bit 5 is the afternoon indicator, still part of the hour
    assign hour_mask = hour_12_q ? 6'h3F : 6'h3F;
    assign countdown_run     = cd_ctrl_q[`BIT_CD_RUN];
    assign countdown_src_sel = cd_ctrl_q[1:0];

    // enabled fields must all match; disabled ones are ignored
    assign any_enabled = ~(minute_match_off & hour_match_off
                         & day_match_off & weekday_match_off);
    assign all_match = any_enabled
        & (minute_match_off  | (minute_alarm_q[6:0] == cur_minute))
        & (hour_match_off    | ((hour_alarm_q[5:0] & hour_mask)
                                == (cur_hour & hour_mask)))
        & (day_match_off     | (day_alarm_q[5:0] == cur_day))
        & (weekday_match_off | (weekday_alarm_q[2:0] == cur_weekday));
    // only a time advance can raise the flag, so a clear is not undone
    assign alarm_set = min_event & all_match;

    // minute tick counted from seconds so both enables land together
    assign tick_set = sec_event & (periodic_1s_en_q
                    | (periodic_60s_en_q & (sec_cnt_q == `MIN_SECONDS)));

    // prescaler period of the selected source, in system clocks
    always @* begin
        case (countdown_src_sel)
            `SRC_4096HZ: pre_max = `T4096_CYC - 1;
            `SRC_64HZ:   pre_max = `T64_CYC - 1;
            default:     pre_max = `T1_CYC - 1;
        endcase
    end

    // second counter serves the 1/60 Hz source and the minute tick
    always @(posedge clk_sys) begin
        if (rst) begin
            sec_cnt_q <= 6'h00;
        end else if (sec_event) begin
            sec_cnt_q <= (sec_cnt_q == `MIN_SECONDS) ? 6'h00 : sec_cnt_q + 6'h01;
        end
    end

    // source tick: prescaler for fast sources, second strobes for slow ones
    always @(posedge clk_sys) begin
        if (rst | ~countdown_run) begin
            pre_q <= 32'h0000_0000;
        end else if (pre_q >= pre_max) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
        end
    end
    always @* begin
        case (countdown_src_sel)
            `SRC_1HZ: src_tick = sec_event;
            `SRC_60S: src_tick = sec_event & (sec_cnt_q == `MIN_SECONDS);
            default:  src_tick = (pre_q >= pre_max);
        endcase
    end

    // reaching one sets the flag and reloads; zero holds the counter
    assign cd_set = countdown_run & src_tick & (cd_n_q != 8'h00)
                  & (cd_count_q == 8'h01);

    always @(posedge clk_sys) begin
        if (rst) begin
            cd_count_q <= `RST_BYTE;
        end else if (reg_wr && reg_addr == `ADDR_CD_VALUE) begin
            cd_count_q <= reg_wdata; // new n takes effect at once
        end else if (countdown_run && src_tick && cd_n_q != 8'h00) begin
            cd_count_q <= (cd_count_q <= 8'h01) ? cd_n_q : cd_count_q - 8'h01;
        end
    end

    // year counter wraps 99 to 00 in BCD
    always @* begin
        year_d = year_q;
        if (year_q == 8'h99) begin
            year_d = 8'h00;
        end else if (year_q[3:0] == 4'h9) begin
            year_d = {year_q[7:4] + 4'h1, 4'h0};
        end else begin
            year_d = {year_q[7:4], year_q[3:0] + 4'h1};
        end
    end

    // register writes and hardware updates
    always @(posedge clk_sys) begin
        if (rst) begin
            year_q            <= `RST_BYTE;
            minute_alarm_q    <= `RST_ALARM;
            hour_alarm_q      <= `RST_ALARM;
            day_alarm_q       <= `RST_ALARM;
            weekday_alarm_q   <= `RST_ALARM;
            cd_ctrl_q         <= `RST_CD_CONTROL;
            cd_n_q            <= `RST_BYTE;
            hour_12_q         <= 1'b0;
            periodic_60s_en_q <= 1'b0;
            periodic_1s_en_q  <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_YEAR_COUNT) begin
                year_q <= reg_wdata;
            end else if (yr_event) begin
                year_q <= year_d;
            end
            if (reg_wr) begin
                if (reg_addr == `ADDR_CLOCK_CONTROL) begin
                    hour_12_q <= reg_wdata[`BIT_HOUR_12];
                end else if (reg_addr == `ADDR_FLAG_CONTROL) begin
                    periodic_60s_en_q <= reg_wdata[`BIT_PERIODIC_60S];
                    periodic_1s_en_q  <= reg_wdata[`BIT_PERIODIC_1S];
                end else if (reg_addr == `ADDR_MINUTE_ALARM) begin
                    minute_alarm_q <= reg_wdata;
                end else if (reg_addr == `ADDR_HOUR_ALARM) begin
                    hour_alarm_q <= reg_wdata & `MASK_HOUR_ALARM;
                end else if (reg_addr == `ADDR_DAY_ALARM) begin
                    day_alarm_q <= reg_wdata & `MASK_DAY_ALARM;
                end else if (reg_addr == `ADDR_WEEKDAY_ALARM) begin
                    weekday_alarm_q <= reg_wdata & `MASK_WEEKDAY_ALARM;
                end else if (reg_addr == `ADDR_CD_CONTROL) begin
                    cd_ctrl_q <= reg_wdata & `MASK_CD_CONTROL;
                end else if (reg_addr == `ADDR_CD_VALUE) begin
                    cd_n_q <= reg_wdata;
                end
            end
        end
    end

    // flags: write ANDs, a same-cycle hardware set wins over the clear
    always @(posedge clk_sys) begin
        if (rst) begin
            alarm_flag_q     <= 1'b0;
            tick_flag_q      <= 1'b0;
            countdown_flag_q <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `ADDR_FLAG_CONTROL) begin
                alarm_flag_q     <= alarm_set | (alarm_flag_q
                                    & reg_wdata[`BIT_ALARM_FLAG]);
                tick_flag_q      <= tick_set | (tick_flag_q
                                    & reg_wdata[`BIT_TICK_FLAG]);
                countdown_flag_q <= cd_set | (countdown_flag_q
                                    & reg_wdata[`BIT_CD_FLAG]);
            end else begin
                alarm_flag_q     <= alarm_flag_q | alarm_set;
                tick_flag_q      <= tick_flag_q | tick_set;
                countdown_flag_q <= countdown_flag_q | cd_set;
            end
        end
    end

    // read data registered one cycle after the strobe
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_q <= `RST_BYTE;
        end else if (reg_rd) begin
            if (reg_addr == `ADDR_CLOCK_CONTROL) begin
                reg_rdata_q <= {5'h00, hour_12_q, 2'h0};
            end else if (reg_addr == `ADDR_FLAG_CONTROL) begin
                reg_rdata_q <= {2'h0, tick_flag_q, 1'b0, alarm_flag_q,
                                countdown_flag_q, periodic_60s_en_q, periodic_1s_en_q};
            end else if (reg_addr == `ADDR_YEAR_COUNT) begin
                reg_rdata_q <= year_q;
            end else if (reg_addr == `ADDR_MINUTE_ALARM) begin
                reg_rdata_q <= minute_alarm_q;
            end else if (reg_addr == `ADDR_HOUR_ALARM) begin
                reg_rdata_q <= hour_alarm_q;
            end else if (reg_addr == `ADDR_DAY_ALARM) begin
                reg_rdata_q <= day_alarm_q;
            end else if (reg_addr == `ADDR_WEEKDAY_ALARM) begin
                reg_rdata_q <= weekday_alarm_q;
            end else if (reg_addr == `ADDR_CD_CONTROL) begin
                reg_rdata_q <= cd_ctrl_q;
            end else if (reg_addr == `ADDR_CD_VALUE) begin
                reg_rdata_q <= cd_count_q; // live count, not n
            end else begin
                reg_rdata_q <= `RST_BYTE;
            end
        end
    end
endmodule // rtc_alarm_timer
`default_nettype wire

/* File: tb/rtc_alarm_assertions.sv */
`default_nettype none
module rtc_alarm_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // register port
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    // calendar strobe, flag levels and the hour format bit
    input wire logic       minute_tick,
    input wire logic       alarm_flag_q,
    input wire logic       tick_flag_q,
    input wire logic       countdown_flag_q,
    input wire logic       hour_12_q
);
    logic [2:0] quiet_q;
    logic [3:0] off_q;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // idle time since the last minute strobe; a clear racing a pending set is not judged
    always_ff @(posedge clk_sys) begin
        if (rst || minute_tick)
            quiet_q <= 3'h0;
        else if (quiet_q != 3'h7)
            quiet_q <= quiet_q + 3'h1;
    end
    // shadow of the four match-off bits, all fields off out of reset
    always_ff @(posedge clk_sys) begin
        if (rst)
            off_q <= 4'hF;
        else if (reg_wr && reg_addr >= 8'h09 && reg_addr <= 8'h0C)
            off_q[reg_addr[1:0] - 2'h1] <= reg_wdata[7];
    end
    // minute strobe edge followed by the flag going up
    sequence s_alarm_set;
        $rose(minute_tick) ##[3:5] $rose(alarm_flag_q);
    endsequence
    c_alarm_set: cover property (s_alarm_set);
    property p_rd_unmapped; reg_rd && reg_addr > 8'h0F |=> reg_rdata_q == 8'h00; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_ctrl; reg_rd && reg_addr == 8'h0E |=> reg_rdata_q[6:2] == 5'h00; endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control spare bits set");
    property p_rd_wkday; reg_rd && reg_addr == 8'h0C |=> reg_rdata_q[6:3] == 4'h0; endproperty
    a_rd_wkday: assert property (p_rd_wkday) else $error("weekday spare bits set");
    property p_rd_hrday; reg_rd && reg_addr[7:1] == 7'h05 |=> !reg_rdata_q[6]; endproperty
    a_rd_hrday: assert property (p_rd_hrday) else $error("hour or day bit 6 set");
    property p_rd_flags;
        reg_rd && reg_addr == 8'h01 |=> reg_rdata_q[5] == $past(tick_flag_q)
            && reg_rdata_q[3] == $past(alarm_flag_q) && reg_rdata_q[2] == $past(countdown_flag_q);
    endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("flag bits misplaced");
    property p_alarm_clr;
        reg_wr && reg_addr == 8'h01 && !reg_wdata[3] && quiet_q > 3'h5 |=> !alarm_flag_q;
    endproperty
    a_alarm_clr: assert property (p_alarm_clr) else $error("alarm flag not cleared");
    property p_flag_keep;
        reg_wr && reg_addr == 8'h01 && reg_wdata[5] && reg_wdata[3] && reg_wdata[2]
            |=> !$fell(alarm_flag_q) && !$fell(tick_flag_q) && !$fell(countdown_flag_q);
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost on write of one");
    property p_alarm_hold; alarm_flag_q && !(reg_wr && reg_addr == 8'h01) |=> alarm_flag_q; endproperty
    a_alarm_hold: assert property (p_alarm_hold) else $error("alarm flag dropped");
    property p_alarm_cause;
        $rose(alarm_flag_q) |-> $past(minute_tick, 3) || $past(minute_tick, 4) || $past(minute_tick, 5);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm set without time step");
    property p_all_off; (&off_q) && !alarm_flag_q |=> !alarm_flag_q; endproperty
    a_all_off: assert property (p_all_off) else $error("alarm set with all fields off");
    property p_hour_fmt; reg_wr && reg_addr == 8'h00 |=> hour_12_q == $past(reg_wdata[2]); endproperty
    a_hour_fmt: assert property (p_hour_fmt) else $error("hour format bit wrong");
endmodule // rtc_alarm_checker
bind rtc_alarm_timer rtc_alarm_checker chk_u (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .minute_tick(minute_tick), .alarm_flag_q(alarm_flag_q), .tick_flag_q(tick_flag_q),
    .countdown_flag_q(countdown_flag_q), .hour_12_q(hour_12_q));
`default_nettype wire

/* File: tb/host_model.sv */
`default_nettype none
module host_model (
    // clock
    input  wire logic       clk_sys,
    // register port towards the device
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one strobe edge per access; released lines show junk so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        #1 d = reg_rdata_q;
    endtask
    // clear only the flags in m: read first so enables go back unchanged
    task automatic clr(input logic [7:0] m);
        logic [7:0] v;
        rd(8'h01, v);
        wr(8'h01, (v | 8'h2C) & ~m);
    endtask
endmodule // host_model
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_sys, rst;
    logic [2:0] tk;
    logic [6:0] c_min;
    logic [5:0] c_hr, c_day;
    logic [2:0] c_wd;
    logic [7:0] v;
    logic [7:0] mdl [16];
    logic [31:0] rs = 32'h0000_0002;
    int         n_errors, total_checks;
    logic [7:0] ra [12] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
                            8'h0F, 8'h10, 8'hFF};
    logic [31:0] al [4] = '{32'h2580_8080, 32'h2513_8080, 32'h2512_0703, 32'h8080_8080};
    logic [3:0] ae = 4'b0101;
    wire logic       reg_wr, reg_rd;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
    wire logic       alarm_flag_q, tick_flag_q, countdown_flag_q, hour_12_q;
    rtc_alarm_timer dut_u (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .minute_tick(tk[0]), .second_tick(tk[1]), .year_tick(tk[2]), .cur_minute(c_min),
        .cur_hour(c_hr), .cur_day(c_day), .cur_weekday(c_wd), .alarm_flag_q(alarm_flag_q),
        .tick_flag_q(tick_flag_q), .countdown_flag_q(countdown_flag_q), .hour_12_q(hour_12_q));
    host_model host_u (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    // readable bits of each place; flags live in the model image of the flag register
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h00: return 8'h04;
            8'h0A, 8'h0B: return 8'hBF;
            8'h0C: return 8'h87;
            8'h0E: return 8'h83;
            8'h08, 8'h09, 8'h0F: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    // model write: flag bits are ANDed, enables stored plainly
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        host_u.wr(a, d);
        // let the write edge settle before any flag or output is looked at
        @(posedge clk_sys);
        if (a == 8'h01)
            mdl[1] = (mdl[1] & d & 8'h2C) | (d & 8'h03);
        else if (a < 8'h10)
            mdl[a[3:0]] = d & msk(a);
    endtask
    task automatic r(input logic [7:0] a);
        host_u.rd(a, v);
        chk(v, (a < 8'h10) ? mdl[a[3:0]] : 8'h00);
    endtask
    task automatic clr_f(input logic [7:0] m);
        host_u.clr(m);
        @(posedge clk_sys);
        mdl[1] = mdl[1] & ~m;
    endtask
    // strobe held three cycles, then wait out the synchroniser latency
    task automatic pulse(input int i);
        tk[i] <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tk[i] <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // hang guard: the sequence needs a few thousand cycles at most
    initial begin
        #400000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        tk = 3'h0;
        c_min = 7'h25;
        c_hr = 6'h12;
        c_day = 6'h07;
        c_wd = 3'h3;
        mdl = '{default: 8'h00};
        for (int i = 9; i < 13; i++)
            mdl[i] = 8'h80;
        mdl[14] = 8'h03;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ra[i]) r(ra[i]);
        foreach (ra[i]) if (ra[i] != 8'h01) begin
            w(ra[i], (ra[i] == 8'h08) ? (rnd() & 8'h77) : rnd());
            r(ra[i]);
        end
        for (int s = 0; s < 4; s++) begin
            w(8'h0E, (rnd() & 8'h7C) | 8'(s));
            r(8'h0E);
        end
        w(8'h08, 8'h99);
        pulse(2);
        mdl[8] = 8'h00;
        r(8'h08);
        w(8'h00, 8'h04);
        chk(8'(hour_12_q), 8'h01);
        for (int k = 0; k < 4; k++) begin
            clr_f(8'h08);
            for (int j = 0; j < 4; j++)
                w(8'h09 + 8'(j), al[k][31 - 8 * j -: 8]);
            pulse(0);
            chk(8'(alarm_flag_q), 8'(ae[k]));
            mdl[1][3] = ae[k];
            r(8'h01);
            w(8'h01, mdl[1] | 8'h2C);
            chk(8'(alarm_flag_q), 8'(ae[k]));
        end
        clr_f(8'h2C);
        w(8'h0E, 8'h82);
        w(8'h0F, 8'h03);
        pulse(1);
        mdl[15] = 8'h02;
        r(8'h0F);
        chk(8'(countdown_flag_q), 8'h00);
        // period is n source ticks: the tick taken at count one sets the flag
        repeat (2) pulse(1);
        chk(8'(countdown_flag_q), 8'h01);
        mdl[1][2] = 1'b1;
        clr_f(8'h04);
        chk(8'(countdown_flag_q), 8'h00);
        repeat (3) pulse(1);
        chk(8'(countdown_flag_q), 8'h01);
        clr_f(8'h04);
        w(8'h0F, 8'h00);
        repeat (3) pulse(1);
        chk(8'(countdown_flag_q), 8'h00);
        w(8'h0E, 8'h02);
        w(8'h0F, 8'h02);
        repeat (2) pulse(1);
        chk(8'(countdown_flag_q), 8'h00);
        w(8'h01, 8'h01);
        pulse(1);
        chk(8'(tick_flag_q), 8'h01);
        mdl[1][5] = 1'b1;
        r(8'h01);
        clr_f(8'h20);
        w(8'h01, 8'h00);
        pulse(1);
        chk(8'(tick_flag_q), 8'h00);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
